// [logic/input_cond_defs.vh]
// constants for the four-input measurement and conditioning block
`ifndef INPUT_COND_DEFS_VH
`define INPUT_COND_DEFS_VH
// register word offsets within a group (address bits 3:2); one 16-byte group per input at idx*0x10
`define OFF_CFG        2'h0
`define OFF_MINR       2'h1
`define OFF_MAXR       2'h2
`define OFF_MEAS       2'h3
`define ADDR_STATUS    8'h40
// configuration field positions
`define CFG_TYPE_LSB   0
`define CFG_CAPDB_LSB  8
`define CFG_SWDB_LSB   12
`define CFG_PULL_BIT   16
`define CFG_ALOW_BIT   17
`define CFG_PPR_BIT    18
`define CFG_RESET      19'h00000
`define MINR_RESET     32'h00000000
`define MAXR_RESET     32'hFFFFFFFF
// sensor type groups
`define GRP_OFF        3'h0
`define GRP_ANA        3'h1
`define GRP_RES        3'h2
`define GRP_FREQ       3'h3
`define GRP_PWM        3'h4
`define GRP_DIG        3'h5
`define GRP_CNT        3'h6
`define GRP_ENC        3'h7
// timing: 10 ns clock, 1 us capture tick
`define CLK_NS         10
`define TICK_NS        1000
`define TICK_DIV       (`TICK_NS / `CLK_NS)
`define CAPF1_NS       111
`define CAPF2_NS       1780
`define CAPF3_NS       14220
`define CAPF1_CYC      ((`CAPF1_NS + `CLK_NS - 1) / `CLK_NS)
`define CAPF2_CYC      ((`CAPF2_NS + `CLK_NS - 1) / `CLK_NS)
`define CAPF3_CYC      ((`CAPF3_NS + `CLK_NS - 1) / `CLK_NS)
`define PWM_FRAME      16'd1000
`define RPM_PER_HZ     60
// resistive auto-range thresholds on the 12-bit sample
`define RES_HI         12'hE66
`define RES_LO         12'h100
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2
`endif

// [logic/input_cond.v]
// four-input measurement and conditioning with an axi4-lite setpoint port
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "input_cond_defs.vh"
module input_cond #(
  parameter [31:0] MS_TICKS   = 32'd1000,
  parameter [31:0] GATE_TICKS = 32'd1000000
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [3:0]  pin_level,
  output reg  [3:0]  pullup_en,
  output reg  [3:0]  excite_sel,
  output reg  [1:0]  adc_chan,
  output reg         adc_start,
  input  wire [11:0] adc_data,
  input  wire        adc_done,
  output reg  [3:0]  input_state
);
  reg  [18:0] cfg_reg  [0:3];
  reg  [31:0] minr_reg [0:3];
  reg  [31:0] maxr_reg [0:3];
  reg  [31:0] meas_reg [0:3];
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg  [10:0] cf_cnt   [0:3];
  reg  [9:0]  db_cnt   [0:3];
  reg  [31:0] edge_cnt [0:3];
  reg  [31:0] freq_reg [0:3];
  reg  [15:0] high_cnt [0:3];
  reg  [15:0] duty_reg [0:3];
  reg  [31:0] ctr_reg  [0:3];
  reg  [11:0] adc_val  [0:3];
  reg  [1:0]  exc_reg  [2:3];
  reg  [3:0]  filt_lvl;
  reg  [3:0]  act_prev;
  reg  [3:0]  db_lvl;
  reg  [3:0]  db_prev;
  reg  [31:0] enc_cnt;
  reg  [1:0]  enc_prev;
  reg  [6:0]  tick_div;
  reg         tick;
  reg  [31:0] ms_cnt;
  reg         ms_tick;
  reg  [31:0] gate_cnt;
  reg  [15:0] frame_cnt;
  reg         adc_busy;
  reg  [31:0] cfg_next;
  wire [3:0]  act_lvl;
  wire        enc_on;
  integer     i;

  function legal_type;
    input [1:0] idx;
    input [6:0] t;
    begin
      case (t)
        7'd0, 7'd12, 7'd13, 7'd20, 7'd21, 7'd40, 7'd41, 7'd42, 7'd50,
        7'd51, 7'd60, 7'd61, 7'd62, 7'd70, 7'd71, 7'd72: legal_type = 1'b1;
        7'd14, 7'd15: legal_type = ~idx[1];
        7'd30, 7'd80: legal_type = idx[1];
        default: legal_type = 1'b0;
      endcase
    end
  endfunction

  function [2:0] grp;
    input [6:0] t;
    begin
      case (t)
        7'd12, 7'd13, 7'd14, 7'd15, 7'd20, 7'd21: grp = `GRP_ANA;
        7'd30: grp = `GRP_RES;
        7'd40, 7'd41, 7'd42: grp = `GRP_FREQ;
        7'd50, 7'd51: grp = `GRP_PWM;
        7'd60, 7'd61, 7'd62: grp = `GRP_DIG;
        7'd70, 7'd71, 7'd72: grp = `GRP_CNT;
        7'd80: grp = `GRP_ENC;
        default: grp = `GRP_OFF;
      endcase
    end
  endfunction

  function [10:0] capf_cycles;
    input [1:0]  sel;
    reg   [31:0] cyc;
    begin
      case (sel)
        2'd1: cyc = `CAPF1_CYC;
        2'd2: cyc = `CAPF2_CYC;
        2'd3: cyc = `CAPF3_CYC;
        default: cyc = 32'd0;
      endcase
      // longest filter is 1422 cycles, so eleven bits hold every choice
      capf_cycles = cyc[10:0];
    end
  endfunction

  function [9:0] db_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'd1: db_ms = 10'd10;
        3'd2: db_ms = 10'd20;
        3'd3: db_ms = 10'd40;
        3'd4: db_ms = 10'd100;
        3'd5: db_ms = 10'd200;
        3'd6: db_ms = 10'd400;
        3'd7: db_ms = 10'd1000;
        default: db_ms = 10'd0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  function [31:0] clamp;
    input [31:0] v;
    input [31:0] mn;
    input [31:0] mx;
    begin
      if (v < mn)
        clamp = mn;
      else if (v > mx)
        clamp = mx;
      else
        clamp = v;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pol
      assign act_lvl[g] = filt_lvl[g] ^ cfg_reg[g][`CFG_ALOW_BIT];
    end
  endgenerate
  assign enc_on = (cfg_reg[2][6:0] == 7'd80) &&
                  (cfg_reg[3][6:0] == 7'd80);

  // setpoint writes; address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= `AXI_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      pullup_en   <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        cfg_reg[i]  <= `CFG_RESET;
        minr_reg[i] <= `MINR_RESET;
        maxr_reg[i] <= `MAXR_RESET;
      end
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        wready     <= 1'b0;
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= `AXI_SLVERR;
        if (aw_addr_reg[7:6] == 2'b00) begin
          case (aw_addr_reg[3:2])
            `OFF_CFG: begin
              if (legal_type(aw_addr_reg[5:4], cfg_next[6:0])) begin
                cfg_reg[aw_addr_reg[5:4]] <= cfg_next[18:0];
                bresp <= `AXI_OKAY;
              end
            end
            `OFF_MINR: begin
              minr_reg[aw_addr_reg[5:4]] <= merge(minr_reg[aw_addr_reg[5:4]],
                                                  w_data_reg, w_strb_reg);
              bresp <= `AXI_OKAY;
            end
            `OFF_MAXR: begin
              maxr_reg[aw_addr_reg[5:4]] <= merge(maxr_reg[aw_addr_reg[5:4]],
                                                  w_data_reg, w_strb_reg);
              bresp <= `AXI_OKAY;
            end
            default: bresp <= `AXI_SLVERR;
          endcase
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      for (i = 0; i < 4; i = i + 1)
        pullup_en[i] <= cfg_reg[i][`CFG_PULL_BIT];
    end
  end

  always @* begin
    cfg_next = merge({13'h0000, cfg_reg[aw_addr_reg[5:4]]}, w_data_reg,
                     w_strb_reg);
    cfg_next[31:19] = 13'h0000;
  end

  // register reads
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `AXI_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `AXI_OKAY;
      rdata   <= 32'h00000000;
      if (araddr[7:6] == 2'b00) begin
        case (araddr[3:2])
          `OFF_CFG:  rdata <= {13'h0000, cfg_reg[araddr[5:4]]};
          `OFF_MINR: rdata <= minr_reg[araddr[5:4]];
          `OFF_MAXR: rdata <= maxr_reg[araddr[5:4]];
          default:   rdata <= meas_reg[araddr[5:4]];
        endcase
      end else if (araddr == `ADDR_STATUS) begin
        rdata <= {18'h00000, adc_busy, enc_on, exc_reg[3], exc_reg[2],
                  input_state, db_lvl};
      end else begin
        rresp <= `AXI_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // shared time base: 1 us tick, 1 ms tick, rate gate, 16-bit frame timer
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_div  <= 7'd0;
      tick      <= 1'b0;
      ms_cnt    <= 32'd0;
      ms_tick   <= 1'b0;
      gate_cnt  <= 32'd0;
      frame_cnt <= 16'd0;
    end else begin
      tick    <= 1'b0;
      ms_tick <= 1'b0;
      if (tick_div == `TICK_DIV - 1) begin
        tick_div <= 7'd0;
        tick     <= 1'b1;
      end else begin
        tick_div <= tick_div + 7'd1;
      end
      if (tick) begin
        ms_cnt    <= (ms_cnt == MS_TICKS - 1) ? 32'd0 : ms_cnt + 32'd1;
        ms_tick   <= (ms_cnt == MS_TICKS - 1);
        gate_cnt  <= (gate_cnt == GATE_TICKS - 1) ? 32'd0 : gate_cnt + 32'd1;
        frame_cnt <= (frame_cnt == `PWM_FRAME - 16'd1) ? 16'd0 :
                     frame_cnt + 16'd1;
      end
    end
  end

  // converter scheduling and resistive excitation auto-ranging
  always @(posedge aclk) begin
    if (!aresetn) begin
      adc_chan  <= 2'd0;
      adc_start <= 1'b0;
      adc_busy  <= 1'b0;
      exc_reg[2] <= 2'd0;
      exc_reg[3] <= 2'd0;
      excite_sel <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        adc_val[i] <= 12'h000;
    end else begin
      adc_start <= 1'b0;
      if (!adc_busy) begin
        if (grp(cfg_reg[adc_chan][6:0]) == `GRP_ANA ||
            grp(cfg_reg[adc_chan][6:0]) == `GRP_RES) begin
          adc_start <= 1'b1;
          adc_busy  <= 1'b1;
        end else begin
          adc_chan <= adc_chan + 2'd1;
        end
      end else if (adc_done) begin
        adc_val[adc_chan] <= adc_data;
        adc_busy <= 1'b0;
        adc_chan <= adc_chan + 2'd1;
        // low reading means too little drive for the load, step current up
        if (adc_chan[1] && grp(cfg_reg[adc_chan][6:0]) == `GRP_RES) begin
          if (adc_data > `RES_HI && exc_reg[adc_chan] != 2'd0)
            exc_reg[adc_chan] <= exc_reg[adc_chan] - 2'd1;
          else if (adc_data < `RES_LO && exc_reg[adc_chan] != 2'd3)
            exc_reg[adc_chan] <= exc_reg[adc_chan] + 2'd1;
        end
      end
      excite_sel <= {exc_reg[3], exc_reg[2]};
    end
  end

  // per-input filtering, debounce, rate, duty, counting and encoder
  always @(posedge aclk) begin
    if (!aresetn) begin
      filt_lvl    <= 4'h0;
      act_prev    <= 4'h0;
      db_lvl      <= 4'h0;
      db_prev     <= 4'h0;
      input_state <= 4'h0;
      enc_cnt     <= 32'd0;
      enc_prev    <= 2'b00;
      for (i = 0; i < 4; i = i + 1) begin
        cf_cnt[i]   <= 11'd0;
        db_cnt[i]   <= 10'd0;
        edge_cnt[i] <= 32'd0;
        freq_reg[i] <= 32'd0;
        high_cnt[i] <= 16'd0;
        duty_reg[i] <= 16'd0;
        ctr_reg[i]  <= 32'd0;
      end
    end else begin
      act_prev <= act_lvl;
      db_prev  <= db_lvl;
      for (i = 0; i < 4; i = i + 1) begin
        // level must stay put for the filter time before it is accepted
        if (pin_level[i] == filt_lvl[i]) begin
          cf_cnt[i] <= 11'd0;
        end else if (cf_cnt[i] >= capf_cycles(cfg_reg[i][9:8])) begin
          filt_lvl[i] <= pin_level[i];
          cf_cnt[i]   <= 11'd0;
        end else begin
          cf_cnt[i] <= cf_cnt[i] + 11'd1;
        end
        // ms granularity: the hold time is exact to within one millisecond
        if (act_lvl[i] == db_lvl[i]) begin
          db_cnt[i] <= 10'd0;
        end else if (db_cnt[i] >= db_ms(cfg_reg[i][14:12])) begin
          db_lvl[i] <= act_lvl[i];
          db_cnt[i] <= 10'd0;
        end else if (ms_tick) begin
          db_cnt[i] <= db_cnt[i] + 10'd1;
        end
        case (cfg_reg[i][6:0])
          7'd60: input_state[i] <= db_lvl[i];
          7'd61: input_state[i] <= ~db_lvl[i];
          7'd62: if (db_lvl[i] && !db_prev[i])
                   input_state[i] <= ~input_state[i];
          default: input_state[i] <= 1'b0;
        endcase
        if (tick && gate_cnt == GATE_TICKS - 1) begin
          freq_reg[i] <= edge_cnt[i] + ((act_lvl[i] && !act_prev[i]) ?
                                        32'd1 : 32'd0);
          edge_cnt[i] <= 32'd0;
        end else if (act_lvl[i] && !act_prev[i]) begin
          edge_cnt[i] <= edge_cnt[i] + 32'd1;
        end
        if (tick) begin
          if (frame_cnt == `PWM_FRAME - 16'd1) begin
            duty_reg[i] <= high_cnt[i] + {15'd0, act_lvl[i]};
            high_cnt[i] <= 16'd0;
          end else if (act_lvl[i]) begin
            high_cnt[i] <= high_cnt[i] + 16'd1;
          end
        end
        if (grp(cfg_reg[i][6:0]) != `GRP_CNT)
          ctr_reg[i] <= 32'd0;
        else if ((act_lvl[i] && !act_prev[i] && cfg_reg[i][6:0] != 7'd71) ||
                 (!act_lvl[i] && act_prev[i] && cfg_reg[i][6:0] != 7'd70))
          ctr_reg[i] <= ctr_reg[i] + 32'd1;
      end
      // single-phase steps only; a double step is a glitch and is dropped
      enc_prev <= filt_lvl[3:2];
      if (!enc_on)
        enc_cnt <= 32'd0;
      else if ((filt_lvl[2] ^ enc_prev[0]) && (filt_lvl[3] ^ enc_prev[1]))
        enc_cnt <= enc_cnt;
      else if (filt_lvl[2] ^ enc_prev[0])
        enc_cnt <= (filt_lvl[2] ^ filt_lvl[3]) ? enc_cnt + 32'd1 :
                   enc_cnt - 32'd1;
      else if (filt_lvl[3] ^ enc_prev[1])
        enc_cnt <= (filt_lvl[2] ^ filt_lvl[3]) ? enc_cnt - 32'd1 :
                   enc_cnt + 32'd1;
    end
  end

  // measurement selection and range clamping
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1)
        meas_reg[i] <= 32'd0;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        meas_reg[i] <= clamp(raw_val_of(i[1:0]), minr_reg[i],
                             maxr_reg[i]);
    end
  end

  function [31:0] raw_val_of;
    input [1:0] k;
    begin
      case (grp(cfg_reg[k][6:0]))
        `GRP_ANA: raw_val_of = {20'h00000, adc_val[k]};
        `GRP_RES: raw_val_of = {18'h00000, exc_reg[{1'b1, k[0]}],
                                adc_val[k]};
        `GRP_FREQ: raw_val_of = cfg_reg[k][`CFG_PPR_BIT] ?
                   freq_reg[k] * `RPM_PER_HZ : freq_reg[k];
        `GRP_PWM: raw_val_of = {16'h0000, duty_reg[k]};
        `GRP_DIG: raw_val_of = {31'h00000000, input_state[k]};
        `GRP_CNT: raw_val_of = ctr_reg[k];
        `GRP_ENC: raw_val_of = enc_on ? enc_cnt : 32'd0;
        default: raw_val_of = 32'd0;
      endcase
    end
  endfunction
endmodule

// [tb/input_cond_props.sv]
// bus, converter and reset assertions for the input conditioning block
`timescale 1ns/1ns
`include "input_cond_defs.vh"
module input_cond_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire [3:0]  pullup_en,
  input wire [3:0]  input_state,
  input wire        adc_start,
  input wire        adc_done
);
  reg conv_busy;

  // a second start before the result would lose a sample
  always @(posedge aclk) begin
    if (!aresetn)
      conv_busy <= 1'b0;
    else
      conv_busy <= adc_start | (conv_busy & ~adc_done);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> pullup_en == 4'h0 && input_state == 4'h0 && !bvalid)
    else $error("outputs not quiet after reset");
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_write_block: assert property (
    awvalid && awready && wvalid && wready |=> !awready && !wready)
    else $error("write channels ready while busy");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_bresp_code: assert property (bvalid |->
    bresp == `AXI_OKAY || bresp == `AXI_SLVERR)
    else $error("bad write response code");
  chk_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  chk_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_conv_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start too long");
  chk_conv_single: assert property (adc_start |-> !conv_busy)
    else $error("conversion started while busy");

  cover property (bvalid && bresp == `AXI_SLVERR);
  cover property ($rose(input_state[0]));
  cover property (adc_done);
endmodule

bind input_cond input_cond_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .pullup_en(pullup_en),
  .input_state(input_state), .adc_start(adc_start), .adc_done(adc_done)
);

// [tb/adc_model.sv]
// converter model: one result per start after a fixed delay
`timescale 1ns/1ns
module adc_model #(
  parameter [11:0] BASE = 12'h7A0,
  parameter integer LAT = 4
) (
  input  wire        aclk,
  input  wire        adc_start,
  input  wire [1:0]  adc_chan,
  output reg  [11:0] adc_data,
  output reg         adc_done
);
  integer   cnt;
  reg [1:0] chan_reg;

  initial begin
    adc_data = 12'h000;
    adc_done = 1'b0;
    cnt = 0;
    chan_reg = 2'h0;
  end

  always @(posedge aclk) begin
    adc_done <= 1'b0;
    // stale data toggles so it never passes for a fresh result
    adc_data <= ~adc_data;
    if (adc_start && cnt == 0) begin
      chan_reg <= adc_chan;
      cnt <= LAT;
    end else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_data <= BASE + {10'h000, chan_reg};
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the input conditioning block
`timescale 1ns/1ns
`include "input_cond_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb, pin_level;
  wire        awready, wready, bvalid, arready, rvalid, adc_start, adc_done;
  wire [1:0]  bresp, rresp, adc_chan;
  wire [31:0] rdata;
  wire [3:0]  pullup_en, excite_sel, input_state;
  wire [11:0] adc_data;
  integer     num_errors, compares, i, c;
  reg  [1:0]  r;
  reg  [31:0] d;

  input_cond #(.MS_TICKS(32'd2), .GATE_TICKS(32'd50)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_level(pin_level), .pullup_en(pullup_en), .excite_sel(excite_sel),
    .adc_chan(adc_chan), .adc_start(adc_start), .adc_data(adc_data),
    .adc_done(adc_done), .input_state(input_state));

  // low readings push the resistive drive up to its top level
  adc_model #(.BASE(12'h0F0)) u_adc (.aclk(aclk), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_data(adc_data), .adc_done(adc_done));

  function automatic bit legal(input integer n, input integer k);
    legal = k == 0 || k == 12 || k == 13 || (k >= 14 && k <= 15 && n < 2)
      || k == 20 || k == 21 || (k == 30 && n >= 2) || (k >= 40 && k <= 42)
      || k == 50 || k == 51 || (k >= 60 && k <= 62) || (k >= 70 && k <= 72)
      || (k == 80 && n >= 2);
  endfunction

  task wr(input [7:0] a, input [31:0] v, output [1:0] resp);
    reg ap, wp;
    begin
      ap = 1'b1;
      wp = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // the slave may take the two channels at different edges
      while (ap || wp) begin
        @(posedge aclk);
        if (ap && awready) begin
          awvalid <= 1'b0;
          ap = 1'b0;
        end
        if (wp && wready) begin
          wvalid <= 1'b0;
          wp = 1'b0;
        end
      end
      while (!bvalid) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] v, output [1:0] resp);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask

  task close_out;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task t_reset;
    begin
      `CHK(pullup_en, 4'h0)
      rd(8'h00, d, r);
      `CHK(d, 32'h00000000)
      rd(8'h08, d, r);
      `CHK(d, 32'hFFFFFFFF)
    end
  endtask

  task t_types;
    begin
      for (i = 0; i < 4; i = i + 2)
        for (c = 0; c < 86; c = c + 1) begin
          wr({i[3:0], 4'h0}, c, r);
          `CHK(r, legal(i, c) ? `AXI_OKAY : `AXI_SLVERR)
        end
      // a refused code must leave the last good one in place
      rd(8'h00, d, r);
      `CHK(d, 32'h00000048)
      rd(8'h20, d, r);
      `CHK(d, 32'h00000050)
      wr(8'h00, 32'h0, r);
      wr(8'h20, 32'h0, r);
    end
  endtask

  task t_pull;
    begin
      wr(8'h10, 32'h0001003C, r);
      repeat (3) @(posedge aclk);
      `CHK(pullup_en, 4'h2)
      wr(8'h10, 32'h0, r);
      repeat (3) @(posedge aclk);
      `CHK(pullup_en, 4'h0)
    end
  endtask

  task t_digital;
    begin
      wr(8'h00, 32'h0000103C, r);
      pin_level <= 4'h1;
      // 10 ms at 200 cycles per ms, with two ms of slack each way
      repeat (1600) @(posedge aclk);
      `CHK(input_state[0], 1'b0)
      repeat (800) @(posedge aclk);
      `CHK(input_state[0], 1'b1)
      rd(8'h0C, d, r);
      `CHK(d, 32'h00000001)
      wr(8'h00, 32'h0002003C, r);
      repeat (20) @(posedge aclk);
      `CHK(input_state[0], 1'b0)
      pin_level <= 4'h0;
      repeat (20) @(posedge aclk);
      `CHK(input_state[0], 1'b1)
      wr(8'h00, 32'h0000023C, r);
      pin_level <= 4'h1;
      repeat (100) @(posedge aclk);
      `CHK(input_state[0], 1'b0)
      pin_level <= 4'h0;
      repeat (250) @(posedge aclk);
      `CHK(input_state[0], 1'b0)
      pin_level <= 4'h1;
      repeat (250) @(posedge aclk);
      `CHK(input_state[0], 1'b1)
      pin_level <= 4'h0;
      wr(8'h00, 32'h0, r);
    end
  endtask

  task t_analog;
    begin
      wr(8'h20, 32'h0000000C, r);
      repeat (300) @(posedge aclk);
      rd(8'h2C, d, r);
      `CHK(d, 32'h000000F2)
      wr(8'h28, 32'h00000080, r);
      repeat (50) @(posedge aclk);
      rd(8'h2C, d, r);
      `CHK(d, 32'h00000080)
      wr(8'h28, 32'hFFFFFFFF, r);
      wr(8'h24, 32'h000007F0, r);
      repeat (50) @(posedge aclk);
      rd(8'h2C, d, r);
      `CHK(d, 32'h000007F0)
    end
  endtask

  task t_unmapped;
    begin
      rd(8'h50, d, r);
      `CHK(r, `AXI_SLVERR)
      `CHK(d, 32'h00000000)
      wr(8'h0C, 32'h00000001, r);
      `CHK(r, `AXI_SLVERR)
    end
  endtask

  task t_modes;
    begin
      wr(8'h10, 32'h0000003D, r);
      repeat (10) @(posedge aclk);
      `CHK(input_state[1], 1'b1)
      pin_level <= 4'h2;
      repeat (10) @(posedge aclk);
      `CHK(input_state[1], 1'b0)
      pin_level <= 4'h0;
      wr(8'h10, 32'h0, r);
      // latched: every rising active edge flips the state
      wr(8'h10, 32'h0000003E, r);
      for (c = 0; c < 3; c = c + 1) begin
        pin_level <= 4'h2;
        repeat (10) @(posedge aclk);
        `CHK(input_state[1], c[0] ? 1'b0 : 1'b1)
        pin_level <= 4'h0;
        repeat (10) @(posedge aclk);
      end
      wr(8'h10, 32'h00000048, r);
      for (c = 0; c < 3; c = c + 1) begin
        pin_level <= 4'h2;
        repeat (10) @(posedge aclk);
        pin_level <= 4'h0;
        repeat (10) @(posedge aclk);
      end
      rd(8'h1C, d, r);
      `CHK(d, 32'h00000006)
      wr(8'h10, 32'h0, r);
    end
  endtask

  task t_freq;
    begin
      wr(8'h10, 32'h00040028, r);
      // 100-cycle period: exactly 50 rising edges in each 50 us gate
      for (c = 0; c < 120; c = c + 1) begin
        pin_level <= 4'h2;
        repeat (50) @(posedge aclk);
        pin_level <= 4'h0;
        repeat (50) @(posedge aclk);
      end
      rd(8'h1C, d, r);
      `CHK(d, 32'h00000BB8)
      wr(8'h10, 32'h0, r);
    end
  endtask

  task t_resist;
    begin
      wr(8'h30, 32'h0000001E, r);
      repeat (300) @(posedge aclk);
      `CHK(excite_sel[3:2], 2'h3)
      rd(8'h3C, d, r);
      `CHK(d, 32'h000030F3)
    end
  endtask

  task t_encoder;
    begin
      wr(8'h20, 32'h00000050, r);
      wr(8'h30, 32'h00000050, r);
      wr(8'h24, 32'h0, r);
      // one full forward cycle, phase a leading phase b
      for (c = 0; c < 4; c = c + 1) begin
        pin_level <= {c[1] ^ c[0], ~c[1], 2'b00};
        repeat (5) @(posedge aclk);
      end
      rd(8'h2C, d, r);
      `CHK(d, 32'h00000004)
      rd(8'h3C, d, r);
      `CHK(d, 32'h00000004)
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    num_errors = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    pin_level = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_types;
    t_pull;
    t_digital;
    t_analog;
    t_modes;
    t_freq;
    t_resist;
    t_encoder;
    t_unmapped;
    close_out;
  end

  // whole run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    close_out;
  end
endmodule
